// ===== design/fdrs_pkg.sv
// constants, field layout and types shared by the drive sequencer files
// assumes a single 40 MHz clock and a synchronous active-high reset
package fdrs_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned US_W       = 18;
  localparam int unsigned TB_W       = 7;

  // times in their own units, counts derived from them
  localparam int unsigned TRIM_ON_TIME_US   = 390;
  localparam int unsigned TRIM_HOLD_TIME_US = 800;
  localparam int unsigned READ_RECOV_US     = 100;
  localparam int unsigned READ_PULSE_US     = 1;
  localparam int unsigned MOTOR_UP_MS       = 250;
  localparam int unsigned STEP_TOTAL_MS     = 20;
  localparam int unsigned INDEX_PULSE_MS    = 4;

  localparam logic [US_W-1:0] TRIM_ON_US   = US_W'(TRIM_ON_TIME_US);
  localparam logic [US_W-1:0] TRIM_HOLD_US = US_W'(TRIM_HOLD_TIME_US);
  localparam logic [US_W-1:0] RECOV_US     = US_W'(READ_RECOV_US);
  localparam logic [US_W-1:0] MOTOR_UP_US  = US_W'(MOTOR_UP_MS * 1000);
  localparam logic [US_W-1:0] SETTLE_US    = US_W'(STEP_TOTAL_MS * 1000);
  localparam logic [US_W-1:0] INDEX_US     = US_W'(INDEX_PULSE_MS * 1000);
  localparam logic [5:0]      RD_PULSE_CYC = 6'(READ_PULSE_US * CYC_PER_US);
  localparam logic [6:0]      MAX_TRACK    = 7'h4f;

  // register map
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_UNIT_LO = 1;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [1:0]  CTRL_UNIT_RST = 2'h0;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_TRIM   = 1;
  localparam int unsigned ST_PROT   = 2;
  localparam int unsigned ST_READY  = 3;
  localparam int unsigned ST_SPUN   = 4;
  localparam int unsigned ST_SETTLD = 5;
  localparam int unsigned ST_PHASE  = 6;
  localparam int unsigned ST_TRACK  = 8;

  // synchronised pin vector positions
  localparam int unsigned PIN_SEL   = 0;
  localparam int unsigned PIN_MOTOR = 4;
  localparam int unsigned PIN_DIR   = 5;
  localparam int unsigned PIN_STEP  = 6;
  localparam int unsigned PIN_WDAT  = 7;
  localparam int unsigned PIN_WGATE = 8;
  localparam int unsigned PIN_SIDE  = 9;
  localparam int unsigned PIN_HOLE  = 10;
  localparam int unsigned PIN_PROT  = 11;
  localparam int unsigned PIN_PEAK  = 12;
  localparam int unsigned PIN_HOME  = 13;
  localparam int unsigned PIN_W     = 14;

  typedef enum logic [1:0] {
    W_IDLE  = 2'b00,
    W_WRITE = 2'b01,
    W_TAIL  = 2'b10
  } fdrs_wr_e;

endpackage

// ===== design/fdrs_tick_if.sv
// carries the microsecond tick from the timebase to the sequencer
// assumes both ends share one clock
interface fdrs_tick_if;
  logic tick_us;
  modport drv (output tick_us);
  modport use_ (input tick_us);
endinterface

// ===== design/fdrs_timebase.sv
// free-running divider giving a one-cycle tick each microsecond
// assumes i_mclk at the package clock rate
module fdrs_timebase
  import fdrs_pkg::*;
#(
  parameter logic [TB_W-1:0] P_DIV = TB_W'(CYC_PER_US)
)(
  input  wire logic i_mclk,
  input  wire logic i_srst,
  fdrs_tick_if.drv  tb
);

  typedef struct packed {
    logic [TB_W-1:0] cnt;
    logic            tick;
  } fdrs_tb_s;

  fdrs_tb_s st_q;
  fdrs_tb_s st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == P_DIV - TB_W'(1))
    begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + TB_W'(1);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tb.tick_us = st_q.tick;

endmodule

// ===== design/fdrs_seq.sv
// write/erase, read, index, track-zero and positioner sequencing of a minifloppy drive
// assumes controller pins and sensors asynchronous, register port on i_mclk
//
// Overview of operation
// R1: trim erase on 390 us after gate
// R2: trim erase held 800 us after gate
// R3: write busy from gate to trim end
// R4: write current on with gate when ready; write current follows gate, selection and protect without checking ready
// R5: write waveform toggles per write pulse
// R6: controller waits 250 ms after motor start
// R7: controller waits 20 ms after last step
// R8: first write pulse 4 to 8 us
// R9: controller adds trailing write pulse
// R10: controller waits 100 us after trim end
// R11: read ready at latest of all delays
// R12: 1 us read pulse per peak
// R13: one shaped index pulse per hole
// R14: protected media disables writing, reports status
// R15: track zero at outer track, home phase
// R16: one stepper phase per track moved
// R17: no positioner motion during writes
// R18: spindle runs only while enabled
// R19: one head by side, read isolated writing
// R20: deselected: inputs ignored, status inactive; head side still drives o_head_sel while deselected
// R21: step acts on trailing edge, selected
// R22: direction low steps inward, high outward
// R23: side low picks second surface
// R24: timebase timed delays, cleared at reset
module fdrs_seq
  import fdrs_pkg::*;
#(
  parameter logic [US_W-1:0] P_TRIM_ON_US   = TRIM_ON_US,
  parameter logic [US_W-1:0] P_TRIM_HOLD_US = TRIM_HOLD_US,
  parameter logic [US_W-1:0] P_MOTOR_UP_US  = MOTOR_UP_US,
  parameter logic [US_W-1:0] P_SETTLE_US    = SETTLE_US,
  parameter logic [US_W-1:0] P_INDEX_US     = INDEX_US,
  parameter logic [6:0]      P_MAX_TRACK    = MAX_TRACK
)(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [3:0]  i_unit_select_n,
  input  wire logic        i_spindle_enable_n,
  input  wire logic        i_direction_n,
  input  wire logic        i_step_pulse_n,
  input  wire logic        i_write_pulse_n,
  input  wire logic        i_write_gate_n,
  input  wire logic        i_head_side_n,
  input  wire logic        i_index_hole,
  input  wire logic        i_protect_sense,
  input  wire logic        i_read_peak,
  input  wire logic        i_home_sense,
  output logic             o_index_pulse_n,
  output logic             o_home_track_n,
  output logic             o_media_protected_n,
  output logic             o_read_pulse_n,
  output logic             o_write_current_en,
  output logic             o_write_wave,
  output logic             o_trim_erase,
  output logic             o_read_isolate,
  output logic      [1:0]  o_head_sel,
  output logic      [3:0]  o_stepper_phase,
  output logic             o_spindle_run
);

  typedef struct packed {
    logic [PIN_W-1:0] sy1;
    logic [PIN_W-1:0] sy2;
    logic [PIN_W-1:0] prv;
    logic             en;
    logic [1:0]       unit;
    logic             sel;
    fdrs_wr_e         wst;
    logic [US_W-1:0]  wcnt;
    logic [US_W-1:0]  recov;
    logic [US_W-1:0]  motor;
    logic [US_W-1:0]  settle;
    logic [US_W-1:0]  idx;
    logic [5:0]       rdc;
    logic [6:0]       track;
    logic [1:0]       phase;
    logic             trim;
    logic             wcur;
    logic             wave;
    logic             idx_n;
    logic             home_n;
    logic             prot_n;
    logic             rd_n;
    logic             isol;
    logic [1:0]       head;
    logic [3:0]       stp;
    logic             spin;
    logic [31:0]      rdata;
  } fdrs_seq_s;

  fdrs_seq_s st_q;
  fdrs_seq_s st_d;

  fdrs_tick_if tick_if ();

  fdrs_timebase u_timebase (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .tb     (tick_if.drv)
  );

  // counts one microsecond tick down, sticking at zero
  function automatic logic [US_W-1:0] dec_us(input logic [US_W-1:0] c, input logic t);
    dec_us = (t && c != '0) ? c - US_W'(1) : c;
  endfunction

  function automatic logic [3:0] phase_drive(input logic [1:0] p);
    phase_drive = 4'h1 << p;
  endfunction

  logic       tick;
  logic       gate_act;
  logic       prot;
  logic       busy;
  logic       wdat_fall;
  logic       step_go;
  logic       spin_act;
  logic       ready;
  logic [6:0] trk_n;

  assign tick = tick_if.tick_us;

  always_comb
  begin
    st_d     = st_q;
    st_d.sy1 = {i_home_sense, i_read_peak, i_protect_sense, i_index_hole, i_head_side_n,
                i_write_gate_n, i_write_pulse_n, i_step_pulse_n, i_direction_n,
                i_spindle_enable_n, i_unit_select_n};
    st_d.sy2 = st_q.sy1;
    st_d.prv = st_q.sy2;

    // register port writes
    if (i_wr && i_addr == REG_CTRL)
    begin
      st_d.en   = i_wdata[CTRL_EN_BIT];
      st_d.unit = i_wdata[CTRL_UNIT_LO +: 2];
    end

    // a deselected drive sees every control input except head side as idle
    st_d.sel  = st_q.en && !st_q.sy2[PIN_SEL + 32'(st_q.unit)];                   // [R20]
    gate_act  = st_q.sel && !st_q.sy2[PIN_WGATE];                                 // [R20]
    prot      = st_q.sy2[PIN_PROT];
    busy      = st_q.wst != W_IDLE;
    wdat_fall = st_q.prv[PIN_WDAT] && !st_q.sy2[PIN_WDAT];
    spin_act  = st_q.sel && !st_q.sy2[PIN_MOTOR];

    // write / trim erase sequencing, all delays on the microsecond tick
    st_d.wcnt  = dec_us(st_q.wcnt, tick);                                         // [R24]
    st_d.recov = dec_us(st_q.recov, tick);
    unique case (st_q.wst)
      W_IDLE:
      begin
        // protected media never starts a write
        if (gate_act && !prot)                                                    // [R14]
        begin
          st_d.wst  = W_WRITE;                                                    // [R3]
          st_d.wcnt = P_TRIM_ON_US;                                               // [R1]
        end
      end
      W_WRITE:
      begin
        if (st_q.wcnt == '0)
          st_d.trim = 1'b1;                                                       // [R1]
        if (!gate_act)
        begin
          st_d.wst  = W_TAIL;
          st_d.wcnt = P_TRIM_HOLD_US;                                             // [R2]
          st_d.trim = 1'b1;                                                       // [R2]
        end
      end
      W_TAIL:
      begin
        // a new gate during the tail continues with trim already on
        if (gate_act && !prot)
        begin
          st_d.wst  = W_WRITE;
          st_d.wcnt = '0;
        end
        else if (st_q.wcnt == '0)
        begin
          st_d.wst   = W_IDLE;                                                    // [R3]
          st_d.trim  = 1'b0;
          st_d.recov = RECOV_US;                                                  // [R10]
        end
      end
    endcase

    st_d.wcur = st_d.wst == W_WRITE && gate_act && !prot && st_d.sel;             // [R4] [R14] [R20]
    if (wdat_fall && st_q.wcur)
      st_d.wave = !st_q.wave;                                                     // [R5]

    // positioner: trailing edge of step, never while writing
    step_go = st_q.sel && !st_q.prv[PIN_STEP] && st_q.sy2[PIN_STEP] && !busy;     // [R21] [R17]
    trk_n   = st_q.track;
    if (step_go)
    begin
      if (!st_q.sy2[PIN_DIR])
      begin
        if (st_q.track != P_MAX_TRACK)
          trk_n = st_q.track + 7'h01;                                             // [R22]
      end
      else if (st_q.track != '0)
      begin
        trk_n = st_q.track - 7'h01;                                               // [R22]
      end
      st_d.settle = P_SETTLE_US;
    end
    else
    begin
      st_d.settle = dec_us(st_q.settle, tick);
    end
    // phase follows only real motion, so end stops cannot skew it
    if (trk_n > st_q.track)
      st_d.phase = st_q.phase + 2'h1;                                             // [R16]
    else if (trk_n < st_q.track)
      st_d.phase = st_q.phase - 2'h1;                                             // [R16]
    st_d.track = trk_n;
    st_d.stp   = phase_drive(st_d.phase);                                         // [R16]

    // spindle run-up timer restarts whenever the motor is dropped
    st_d.spin  = spin_act;                                                        // [R18]
    st_d.motor = spin_act ? dec_us(st_q.motor, tick) : P_MOTOR_UP_US;

    // index pulse shaper on the rising edge of the hole sensor
    if (!st_q.prv[PIN_HOLE] && st_q.sy2[PIN_HOLE])
      st_d.idx = P_INDEX_US;                                                      // [R13]
    else
      st_d.idx = dec_us(st_q.idx, tick);

    // read pulse; peaks during a pulse are dropped to keep its width fixed
    if (st_q.rdc != '0)
      st_d.rdc = st_q.rdc - 6'h01;
    else if (!st_q.prv[PIN_PEAK] && st_q.sy2[PIN_PEAK] && st_q.sel && !busy)
      st_d.rdc = RD_PULSE_CYC;                                                    // [R12]

    ready = st_q.spin && st_q.motor == '0 && st_q.settle == '0 && !busy
            && st_q.recov == '0;                                                  // [R11]

    // interface status, all inactive high while deselected; read isolate and head select are not gated by selection
    st_d.idx_n  = !(st_d.sel && st_d.idx != '0);                                  // [R13] [R20]
    st_d.home_n = !(st_d.sel && st_d.track == '0 && st_d.phase == '0
                    && st_q.sy2[PIN_HOME]);                                       // [R15] [R20]
    st_d.prot_n = !(st_d.sel && prot);                                            // [R14] [R20]
    st_d.rd_n   = !(st_d.sel && st_d.rdc != '0);                                  // [R12] [R20]
    st_d.isol   = st_d.wst != W_IDLE;                                             // [R19]
    st_d.head   = st_q.sy2[PIN_SIDE] ? 2'h1 : 2'h2;                               // [R19] [R23]

    st_d.rdata = '0;
    if (i_rd && i_addr == REG_CTRL)
    begin
      st_d.rdata[CTRL_EN_BIT]        = st_q.en;
      st_d.rdata[CTRL_UNIT_LO +: 2]  = st_q.unit;
    end
    else if (i_rd && i_addr == REG_STATUS)
    begin
      st_d.rdata[ST_BUSY]       = busy;
      st_d.rdata[ST_TRIM]       = st_q.trim;
      st_d.rdata[ST_PROT]       = prot;
      st_d.rdata[ST_READY]      = ready;
      st_d.rdata[ST_SPUN]       = st_q.spin && st_q.motor == '0;
      st_d.rdata[ST_SETTLD]     = st_q.settle == '0;
      st_d.rdata[ST_PHASE +: 2] = st_q.phase;
      st_d.rdata[ST_TRACK +: 7] = st_q.track;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q        <= '0;                                                          // [R24]
      st_q.sy1    <= '1;
      st_q.sy2    <= '1;
      st_q.prv    <= '1;
      st_q.en     <= CTRL_EN_RST;
      st_q.unit   <= CTRL_UNIT_RST;
      st_q.wst    <= W_IDLE;
      st_q.motor  <= P_MOTOR_UP_US;
      st_q.idx_n  <= 1'b1;
      st_q.home_n <= 1'b1;
      st_q.prot_n <= 1'b1;
      st_q.rd_n   <= 1'b1;
      st_q.head   <= 2'h1;
      st_q.stp    <= 4'h1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_rdata             = st_q.rdata;
  assign o_index_pulse_n     = st_q.idx_n;
  assign o_home_track_n      = st_q.home_n;
  assign o_media_protected_n = st_q.prot_n;
  assign o_read_pulse_n      = st_q.rd_n;
  assign o_write_current_en  = st_q.wcur;
  assign o_write_wave        = st_q.wave;
  assign o_trim_erase        = st_q.trim;
  assign o_read_isolate      = st_q.isol;
  assign o_head_sel          = st_q.head;
  assign o_stepper_phase     = st_q.stp;
  assign o_spindle_run       = st_q.spin;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  a_trim_on_delay: assert property ((st_q.wst == W_WRITE && st_q.wcnt != '0) |-> !st_q.trim) // [R1]
    else $error("trim erase on before its delay");
  a_trim_hold_tail: assert property ((st_q.wst == W_TAIL) |-> st_q.trim) // [R2]
    else $error("trim erase dropped during tail");
  a_busy_start: assert property ((st_q.wst == W_IDLE && gate_act && !prot) |=> st_q.wst == W_WRITE && o_read_isolate) // [R3]
    else $error("write busy did not start with gate");
  a_busy_end_trim: assert property ((st_q.wst == W_TAIL && $past(st_q.wst) == W_TAIL) ##1 (st_q.wst == W_IDLE)
                                   |-> !o_trim_erase && st_q.recov == RECOV_US) // [R3]
    else $error("busy end not tied to trim end");
  a_wcur_cause: assert property (o_write_current_en |-> st_q.wst == W_WRITE && st_q.sel // [R4]
                                 && $past(gate_act && !prot))
    else $error("write current without gate or with protect");
  a_wave_toggle: assert property ((wdat_fall && st_q.wcur) |=> o_write_wave != $past(o_write_wave)) // [R5]
    else $error("write waveform missed a toggle");
  a_read_width: assert property ($fell(o_read_pulse_n) && st_q.sel |-> ##40 o_read_pulse_n) // [R12]
    else $error("read pulse longer than 1 us");
  a_read_low: assert property ($fell(o_read_pulse_n) |-> ##39 (!o_read_pulse_n || !st_q.sel)) // [R12]
    else $error("read pulse shorter than 1 us");
  a_home_track: assert property (!o_home_track_n |-> st_q.track == '0 && st_q.phase == '0) // [R15]
    else $error("track zero away from home");
  a_phase_step: assert property ((st_q.track != $past(st_q.track)) |->
                                 (2'(st_q.phase - $past(st_q.phase)) inside {2'h1, 2'h3})) // [R16]
    else $error("stepper phase not one per track");
  a_step_blocked: assert property ((st_q.wst != W_IDLE) |=> st_q.track == $past(st_q.track)) // [R17]
    else $error("head moved during write");
  a_head_onehot: assert property ($onehot(o_head_sel)) // [R19]
    else $error("head select not one-hot");
  a_desel_quiet: assert property (!st_q.sel |-> o_index_pulse_n && o_home_track_n && o_media_protected_n
                                  && o_read_pulse_n && !o_write_current_en) // [R20]
    else $error("deselected drive shows status");

  c_write_cycle: cover property ((st_q.wst == W_TAIL) ##1 (st_q.wst == W_IDLE));
  c_step_in: cover property (step_go && !st_q.sy2[PIN_DIR]);
  c_read_pulse: cover property ($fell(o_read_pulse_n));
  c_index: cover property ($fell(o_index_pulse_n));

endmodule

// ===== testbench/fdrs_ctrl_model.sv
// controller-side model that drives the drive's interface lines
// assumes one bench thread calls its tasks, all lines change after a rising edge
module fdrs_ctrl_model
  import fdrs_pkg::*;
#(
  parameter int P_MOTOR_CYC  = 1000,
  parameter int P_SETTLE_CYC = 480
)(
  input  wire logic       i_mclk,
  output logic      [3:0] o_unit_select_n,
  output logic            o_spindle_enable_n,
  output logic            o_direction_n,
  output logic            o_step_pulse_n,
  output logic            o_write_pulse_n,
  output logic            o_write_gate_n,
  output logic            o_head_side_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_unit_select_n    = 4'hf;
    o_spindle_enable_n = 1'b1;
    o_direction_n      = 1'b1;
    o_step_pulse_n     = 1'b1;
    o_write_pulse_n    = 1'b1;
    o_write_gate_n     = 1'b1;
    o_head_side_n      = 1'b1;
  end

  task automatic sel(input logic [3:0] s);
    @(posedge i_mclk);
    o_unit_select_n <= s;
  endtask

  task automatic side(input logic s);
    @(posedge i_mclk);
    o_head_side_n <= s;
  endtask

  // no transfer until the spindle has had its run-up time
  task automatic motor_on();
    @(posedge i_mclk);
    o_spindle_enable_n <= 1'b0;
    repeat (P_MOTOR_CYC) @(posedge i_mclk);
  endtask

  // direction held steady around the trailing edge
  task automatic step(input logic dir_n, input bit settle);
    @(posedge i_mclk);
    o_direction_n  <= dir_n;
    o_step_pulse_n <= 1'b0;
    repeat (12) @(posedge i_mclk);
    o_step_pulse_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
    if (settle)
      repeat (P_SETTLE_CYC) @(posedge i_mclk);
  endtask

  task automatic gate(input logic v);
    @(posedge i_mclk);
    o_write_gate_n <= v;
  endtask

  task automatic wpulse();
    @(posedge i_mclk);
    o_write_pulse_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_write_pulse_n <= 1'b1;
  endtask
endmodule

// ===== testbench/fdrs_seq_tb.sv
// self-checking bench for the drive sequencer with scaled delay parameters
// assumes the controller model drives the pins, the bench the sensors and registers
`define FDRS_CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module fdrs_seq_tb;
  import fdrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_mclk, i_srst, i_wr, i_rd, hole, prot, peak, home;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [3:0]  sel_n, phase;
  logic        mot_n, dir_n, stp_n, wp_n, wg_n, side_n;
  logic        idx_n, home_n, prot_n, rp_n, wce, wave, trim, iso, spin, w0;
  logic [1:0]  hsel;
  logic [3:0]  ph [2];
  int          fails, check_count, cyc, n;

  // delays scaled down so a run stays within a few hundred microsecond ticks
  localparam logic [US_W-1:0] TB_TRIM_ON   = 18'h0_0005;
  localparam logic [US_W-1:0] TB_TRIM_HOLD = 18'h0_0008;
  localparam logic [US_W-1:0] TB_MOTOR_UP  = 18'h0_0014;
  localparam logic [US_W-1:0] TB_SETTLE    = 18'h0_000a;
  localparam logic [US_W-1:0] TB_INDEX     = 18'h0_0006;

  fdrs_ctrl_model ctl (
    .i_mclk(i_mclk), .o_unit_select_n(sel_n), .o_spindle_enable_n(mot_n), .o_direction_n(dir_n),
    .o_step_pulse_n(stp_n), .o_write_pulse_n(wp_n), .o_write_gate_n(wg_n), .o_head_side_n(side_n));

  fdrs_seq #(.P_TRIM_ON_US(TB_TRIM_ON), .P_TRIM_HOLD_US(TB_TRIM_HOLD), .P_MOTOR_UP_US(TB_MOTOR_UP),
    .P_SETTLE_US(TB_SETTLE), .P_INDEX_US(TB_INDEX)) uut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_unit_select_n(sel_n), .i_spindle_enable_n(mot_n), .i_direction_n(dir_n),
    .i_step_pulse_n(stp_n), .i_write_pulse_n(wp_n), .i_write_gate_n(wg_n), .i_head_side_n(side_n),
    .i_index_hole(hole), .i_protect_sense(prot), .i_read_peak(peak), .i_home_sense(home),
    .o_index_pulse_n(idx_n), .o_home_track_n(home_n), .o_media_protected_n(prot_n), .o_read_pulse_n(rp_n),
    .o_write_current_en(wce), .o_write_wave(wave), .o_trim_erase(trim), .o_read_isolate(iso),
    .o_head_sel(hsel), .o_stepper_phase(phase), .o_spindle_run(spin));

  initial
  begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic wt(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic wrap_up();
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the roughly 9k cycles the run needs
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      wrap_up();
    end
  end

  task automatic t_reset();
    `FDRS_CHK({idx_n, home_n, rp_n, wce, trim, iso, spin, hsel, phase}, 13'h1c11)
    prot <= 1'b1;
    ctl.motor_on();
    `FDRS_CHK({prot_n, spin}, 2'b10)
    prot <= 1'b0;
    rd(REG_CTRL, d);
    `FDRS_CHK(d, 32'h0000_0001)
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, d);
    `FDRS_CHK(d, 32'h0000_0000)
  endtask

  task automatic t_select();
    ctl.sel(4'he);
    ctl.motor_on();
    `FDRS_CHK({spin, home_n}, 2'b10)
    wr(REG_CTRL, 32'h0000_0003);
    wt(6);
    `FDRS_CHK({spin, home_n}, 2'b01)
    wr(REG_CTRL, 32'h0000_0001);
    wt(6);
    for (n = 0; n < 2; n++)
    begin
      ctl.side(n[0]);
      wt(6);
      `FDRS_CHK(hsel, n[0] ? 2'b01 : 2'b10)
    end
  endtask

  task automatic t_step();
    ctl.step(1'b1, 1'b1);
    `FDRS_CHK(phase, 4'h1)
    for (int i = 0; i < 2; i++)
    begin
      ph[i] = phase;
      ctl.step(1'b0, 1'b0);
      `FDRS_CHK(phase !== ph[i] && $onehot(phase), 1'b1)
      `FDRS_CHK(home_n, 1'b1)
    end
    fork
      ctl.step(1'b1, 1'b1);
      begin
        wt(8);
        `FDRS_CHK(phase !== ph[1], 1'b1)
      end
    join
    `FDRS_CHK(phase, ph[1])
    ctl.step(1'b1, 1'b1);
    `FDRS_CHK({phase, home_n}, 5'h02)
    home <= 1'b0;
    wt(6);
    `FDRS_CHK(home_n, 1'b1)
    home <= 1'b1;
    wt(6);
    `FDRS_CHK(home_n, 1'b0)
    rd(REG_STATUS, d);
    `FDRS_CHK({d[ST_TRACK +: 7], d[ST_PHASE +: 2], d[ST_SETTLD], d[ST_SPUN]}, 11'h003)
  endtask

  task automatic t_pulses();
    peak <= 1'b1;
    for (n = 0; n < 20 && rp_n !== 1'b0; n++) wt(1);
    peak <= 1'b0;
    for (n = 0; n < 100 && rp_n === 1'b0; n++) wt(1);
    `FDRS_CHK(n, 40)
    hole <= 1'b1;
    for (n = 0; n < 20 && idx_n !== 1'b0; n++) wt(1);
    hole <= 1'b0;
    for (n = 0; n < 400 && idx_n === 1'b0; n++) wt(1);
    `FDRS_CHK(n inside {[200:245]}, 1'b1)
  endtask

  task automatic t_write();
    ctl.gate(1'b0);
    wt(150);
    `FDRS_CHK({wce, iso, trim}, 3'b110)
    wt(100);
    `FDRS_CHK(trim, 1'b1)
    // first data pulse some 6 us after the gate
    w0 = wave;
    ctl.wpulse();
    wt(4);
    `FDRS_CHK(wave, ~w0)
    ctl.wpulse();
    wt(4);
    `FDRS_CHK(wave, w0)
    ctl.step(1'b0, 1'b0);
    `FDRS_CHK(phase, 4'h1)
    rd(REG_STATUS, d);
    `FDRS_CHK(d[ST_BUSY], 1'b1)
    ctl.gate(1'b1);
    wt(10);
    `FDRS_CHK(wce, 1'b0)
    wt(250);
    `FDRS_CHK({trim, iso}, 2'b11)
    wt(90);
    `FDRS_CHK({trim, iso}, 2'b00)
    rd(REG_STATUS, d);
    `FDRS_CHK(d[ST_READY], 1'b0)
    wt(4100);
    rd(REG_STATUS, d);
    `FDRS_CHK(d[ST_READY], 1'b1)
  endtask

  task automatic t_protect();
    prot <= 1'b1;
    wt(6);
    `FDRS_CHK(prot_n, 1'b0)
    ctl.gate(1'b0);
    wt(12);
    `FDRS_CHK({wce, iso}, 2'b00)
    ctl.gate(1'b1);
    prot <= 1'b0;
    wt(6);
    `FDRS_CHK(prot_n, 1'b1)
  endtask

  initial
  begin
    {i_srst, i_wr, i_rd, hole, prot, peak} = 6'h20;
    home    = 1'b1;
    i_addr  = 8'h00;
    i_wdata = 32'h0000_0000;
    wt(6);
    i_srst <= 1'b0;
    wt(1);
    t_reset();
    t_select();
    t_step();
    t_pulses();
    t_write();
    t_protect();
    wrap_up();
  end
endmodule
